// *** shared/gwt_pkg.sv ***
package gwt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE_CONFIG = 8'h00;
    localparam logic [7:0] OFS_EDGE_CONFIG = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_COUNTER = 8'h0C;
    localparam logic [7:0] OFS_TRIGGER = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_PRESCALE = 8'h18;

    // Trigger register bits
    localparam int TRG_START_BIT = 0;
    localparam int TRG_STOP_BIT = 1;

    // Status register bits
    localparam int STS_ENABLED_BIT = 0;
    localparam int STS_COUNTING_BIT = 1;

    // Reset values and counter constants
    localparam logic [15:0] MODE_CONFIG_RST = 16'h0000;
    localparam logic [1:0] EDGE_CONFIG_RST = 2'h0;
    localparam logic [31:0] COMPARE_RST = 32'h0000_0000;
    localparam logic [31:0] COUNTER_RST = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] COUNTER_ZERO = 32'h0000_0000;

    // Edge select codes
    localparam logic [1:0] EDGE_LOW_WIDTH = 2'h2;
    localparam logic [1:0] EDGE_HIGH_WIDTH = 2'h3;

    // Mode field code for gate count operation
    localparam logic [3:0] MODE_GATE_COUNT = 4'hC;

    // Mode field code for period count detection
    localparam logic [3:0] MODE_PERIOD_COUNT = 4'hD;

    // Prescaler reset dividers, operation clock period = value + 1 bus cycles
    localparam logic [7:0] DIV0_RST = 8'h00;
    localparam logic [7:0] DIV1_RST = 8'h01;
    localparam logic [7:0] DIV2_RST = 8'h03;
    localparam logic [7:0] DIV3_RST = 8'h07;

    // Time base
    localparam int CLK_PERIOD_NS = 100;

    // AHB codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HSIZE_WORD = 2'h2;

    // Mode configuration layout
    typedef struct packed {
        logic [1:0] operation_clock_select;
        logic [1:0] count_clock_source;
        logic primary_channel_bit;
        logic [2:0] trigger_source_select;
        logic [1:0] counter_output_select;
        logic reserved;
        logic [3:0] operating_mode_field;
        logic start_interrupt_bit;
    } gwt_mode_t;

    // Latched AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } gwt_aphase_t;

endpackage

// *** verilog/gwt_edge_sampler.sv ***
`timescale 1ns/10ps
module gwt_edge_sampler (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Operation clock tick and pin
    input wire logic tick,
    input wire logic pin_async,
    // Detected edges, one tick each
    output logic rise,
    output logic fall
);

    logic sync1_r;
    logic sync2_r;
    logic samp_r;
    logic prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_async;
            sync2_r <= sync1_r;
        end
    end

    // [RULE23] Sample on tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (tick) begin
            samp_r <= sync2_r;
            prev_r <= samp_r;
        end
    end

    assign rise = samp_r & ~prev_r;
    assign fall = ~samp_r & prev_r;

endmodule

// *** verilog/gwt_timer.sv ***
`timescale 1ns/10ps
// Contract
// [RULE1] Writing one to stop trigger clears the enabled flag, halting counter.
// [RULE2] Stopped channel freezes counter at present value until restarted.
// [RULE3] Stopped channel ignores all qualifying input edges.
// [RULE4] In period count mode, restart begins counting from zero.
// [RULE5] Software loads compare register with all ones before use.
// [RULE6] Writing one to start trigger sets enabled flag and arms counter.
// [RULE7] First start edge after enable loads all ones, then decrements.
// [RULE8] Stop edge halts decrementing and holds the value.
// [RULE9] Next start edge resumes decrementing from held value, no reload.
// [RULE10] At zero: interrupt, reload all ones, keep counting until stop edge.
// [RULE11] Edge select 10b: falling edge starts, rising edge stops.
// [RULE12] Edge select 11b: rising edge starts, falling edge stops.
// [RULE13] No restart while operating; stop first.
// [RULE14] Clock select bits 15:14 pick one of four operation clocks.
// [RULE15] Software sets count clock source bits 13:12 to 00.
// [RULE16] Software writes primary bit 0 and output select bits 00.
// [RULE17] Software sets trigger source bits 10:8 to 010.
// [RULE18] Software sets mode field bits 4:1 to 1100.
// [RULE19] Start-interrupt bit clear: no interrupt at operation start.
// [RULE20] Software keeps simultaneous rewrite enable and mode at zero.
// [RULE21] Function never drives the channel output pin.
// [RULE22] Start and stop trigger bits clear themselves after a write.
// [RULE23] Input sampled on operation clock; one operation clock uncertainty.
// [RULE24] Counter and compare are 32 bits; counter readable without disturbing.
// [RULE25] Interrupt is a one operation clock pulse when counter hits zero.
module gwt_timer (
    // AHB-Lite clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timer pins
    input wire logic timer_input_pin,
    output logic timer_output_pin,
    output logic timer_output_pin_oe,
    // Interrupt
    output logic channel_interrupt
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_COUNT = 2'b10,
        ST_HOLD = 2'b11
    } gwt_state_t;

    gwt_pkg::gwt_mode_t mode_r;
    gwt_pkg::gwt_aphase_t aph_r;
    gwt_state_t state_r;
    gwt_state_t state_nxt;
    logic [1:0] edge_cfg_r;
    logic [31:0] compare_r;
    logic [31:0] counter_r;
    logic [31:0] counter_nxt;
    logic [31:0] rdata_nxt;
    logic [7:0] div_r [4];
    logic [7:0] pre_cnt_r [4];
    logic [3:0] pre_tick;
    logic tick;
    logic pin_rise;
    logic pin_fall;
    logic start_edge;
    logic stop_edge;
    logic enabled_r;
    logic start_trig;
    logic stop_trig;
    logic wr_en;
    logic irq_r;
    logic irq_pend_r;
    logic [31:0] rdata_r;
    logic first_r;
    logic reload;
    logic period_mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r <= '0;
        end else if (hready) begin
            aph_r.valid <= hsel & (htrans == gwt_pkg::HTRANS_NONSEQ);
            aph_r.write <= hwrite;
            aph_r.addr <= haddr[7:0];
        end
    end

    assign wr_en = aph_r.valid & aph_r.write;

    // [RULE6] Start trigger decode
    assign start_trig = wr_en & hit(aph_r.addr, gwt_pkg::OFS_TRIGGER)
        & hwdata[gwt_pkg::TRG_START_BIT];
    // [RULE1] Stop trigger decode
    assign stop_trig = wr_en & hit(aph_r.addr, gwt_pkg::OFS_TRIGGER)
        & hwdata[gwt_pkg::TRG_STOP_BIT];

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= gwt_pkg::MODE_CONFIG_RST;
            edge_cfg_r <= gwt_pkg::EDGE_CONFIG_RST;
            compare_r <= gwt_pkg::COMPARE_RST;
        end else if (wr_en) begin
            if (hit(aph_r.addr, gwt_pkg::OFS_MODE_CONFIG)) begin
                mode_r <= hwdata[15:0];
            end
            if (hit(aph_r.addr, gwt_pkg::OFS_EDGE_CONFIG)) begin
                edge_cfg_r <= hwdata[1:0];
            end
            // [RULE5] Compare loaded by software
            if (hit(aph_r.addr, gwt_pkg::OFS_COMPARE)) begin
                compare_r <= hwdata;
            end
        end
    end

    // Prescaler dividers, writable so software can tune operation clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r[0] <= gwt_pkg::DIV0_RST;
            div_r[1] <= gwt_pkg::DIV1_RST;
            div_r[2] <= gwt_pkg::DIV2_RST;
            div_r[3] <= gwt_pkg::DIV3_RST;
        end else if (wr_en && hit(aph_r.addr, gwt_pkg::OFS_PRESCALE)) begin
            for (int i = 0; i < 4; i++) begin
                div_r[i] <= hwdata[8*i +: 8];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                pre_cnt_r[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                pre_cnt_r[i] <= pre_tick[i] ? 8'h00 : pre_cnt_r[i] + 8'h01;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pre_tick[i] = (pre_cnt_r[i] >= div_r[i]);
        end
    end

    // [RULE14] Operation clock select
    assign tick = pre_tick[mode_r.operation_clock_select];

    gwt_edge_sampler u_sampler (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .pin_async(timer_input_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // [RULE11] Low width edges
    // [RULE12] High width edges
    assign start_edge = tick & ((edge_cfg_r == gwt_pkg::EDGE_HIGH_WIDTH) ? pin_rise :
        (edge_cfg_r == gwt_pkg::EDGE_LOW_WIDTH) ? pin_fall : 1'b0);
    assign stop_edge = tick & ((edge_cfg_r == gwt_pkg::EDGE_HIGH_WIDTH) ? pin_fall :
        (edge_cfg_r == gwt_pkg::EDGE_LOW_WIDTH) ? pin_rise : 1'b0);

    // Enabled flag; stop wins if both triggers written together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enabled_r <= 1'b0;
        end else if (stop_trig) begin
            // [RULE1] Stop clears flag
            enabled_r <= 1'b0;
        end else if (start_trig) begin
            // [RULE6] Start sets flag
            enabled_r <= 1'b1;
        end
    end

    // Count state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_trig && !stop_trig) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (stop_trig) begin
                    state_nxt = ST_IDLE;
                end else if (start_edge) begin
                    state_nxt = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (stop_trig) begin
                    state_nxt = ST_IDLE;
                end else if (stop_edge) begin
                    // [RULE8] Stop edge holds
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (stop_trig) begin
                    state_nxt = ST_IDLE;
                end else if (start_edge) begin
                    // [RULE9] Resume without reload
                    state_nxt = ST_COUNT;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // [RULE13] Start trigger ignored while operating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reload = (counter_r == 32'h0000_0000);

    // [RULE4] Period count mode
    assign period_mode = (mode_r.operating_mode_field == gwt_pkg::MODE_PERIOD_COUNT);

    // Counter next value
    always_comb begin
        counter_nxt = counter_r;
        if (state_r == ST_WAIT && start_edge && !stop_trig) begin
            // [RULE4] [RULE7] Zero or compare register value
            counter_nxt = period_mode ? gwt_pkg::COUNTER_ZERO : compare_r;
        end else if (state_r == ST_COUNT && tick && !stop_trig && period_mode) begin
            // Period count runs upward
            counter_nxt = counter_r + gwt_pkg::ONE;
        end else if (state_r == ST_COUNT && tick && !stop_trig) begin
            // [RULE10] Reload at zero
            counter_nxt = reload ? compare_r : counter_r - gwt_pkg::ONE;
        end
    end

    // [RULE2] Frozen unless counting
    // [RULE3] Edges ignored when stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_r <= gwt_pkg::COUNTER_RST;
        end else begin
            counter_r <= counter_nxt;
        end
    end

    // Marks first count cycle after start, used for start interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_r <= 1'b0;
        end else if (state_r == ST_WAIT && start_edge) begin
            first_r <= 1'b1;
        end else if (tick) begin
            first_r <= 1'b0;
        end
    end

    // [RULE25] One operation clock pulse at zero
    // [RULE19] Start interrupt only when bit set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pend_r <= 1'b0;
        end else if (tick) begin
            irq_pend_r <= (state_r == ST_COUNT && reload && !stop_trig && !first_r
                && !period_mode) || (first_r && mode_r.start_interrupt_bit);
        end
    end

    // Interrupt held high for the whole operation clock period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else if (tick) begin
            irq_r <= irq_pend_r;
        end
    end

    assign channel_interrupt = irq_r;

    // [RULE21] Output pin never driven
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_output_pin <= 1'b0;
            timer_output_pin_oe <= 1'b0;
        end else begin
            timer_output_pin <= 1'b0;
            timer_output_pin_oe <= 1'b0;
        end
    end

    // [RULE24] Read mux, reads have no side effect
    // [RULE22] Trigger register reads zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (haddr[7:0])
            gwt_pkg::OFS_MODE_CONFIG: rdata_nxt = {16'h0000, mode_r};
            gwt_pkg::OFS_EDGE_CONFIG: rdata_nxt = {30'h0000_0000, edge_cfg_r};
            gwt_pkg::OFS_COMPARE: rdata_nxt = compare_r;
            gwt_pkg::OFS_COUNTER: rdata_nxt = counter_nxt;
            gwt_pkg::OFS_STATUS: rdata_nxt = {30'h0000_0000,
                state_nxt == ST_COUNT, enabled_r & ~stop_trig | start_trig & ~stop_trig};
            gwt_pkg::OFS_PRESCALE: rdata_nxt = {div_r[3], div_r[2], div_r[1], div_r[0]};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data registered at end of address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (hready && hsel && htrans == gwt_pkg::HTRANS_NONSEQ && !hwrite) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign hrdata = rdata_r;

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule

// *** tb/gwt_pin_model.sv ***
`timescale 1ns/10ps
module gwt_pin_model (
    // Bench side
    input wire logic level,
    input wire logic [3:0] lag,
    // Measured signal
    output logic pin
);
    initial pin = 1'b0;
    always @(level) pin <= #(lag * 7 + 3) level;
endmodule

// *** tb/gwt_timer_props.sv ***
`timescale 1ns/10ps
module gwt_timer_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic timer_input_pin,
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_oe,
    input wire logic channel_interrupt
);
    logic ap_v_r, ap_w_r, en_r, lv_r;
    logic [7:0] ap_a_r;
    logic [31:0] cmp_r, lc_r;
    // Back-to-back read after write sees the updated status
    wire logic rd = ap_v_r && !ap_w_r && hready;
    wire logic wr = ap_v_r && ap_w_r && hready;
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_v_r <= 1'b0;
            ap_w_r <= 1'b0;
            ap_a_r <= 8'h00;
        end else if (hready) begin
            ap_v_r <= hsel && htrans == gwt_pkg::HTRANS_NONSEQ;
            ap_w_r <= hwrite;
            ap_a_r <= haddr[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r <= 1'b0;
            cmp_r <= gwt_pkg::COMPARE_RST;
        end else if (wr) begin
            if (ap_a_r == gwt_pkg::OFS_COMPARE) cmp_r <= hwdata;
            if (ap_a_r == gwt_pkg::OFS_TRIGGER && hwdata[1:0] != 2'h0)
                en_r <= !hwdata[gwt_pkg::TRG_STOP_BIT];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lv_r <= 1'b0;
            lc_r <= 32'h0000_0000;
        end else if (en_r) begin
            lv_r <= 1'b0;
        end else if (rd && ap_a_r == gwt_pkg::OFS_COUNTER) begin
            lv_r <= 1'b1;
            lc_r <= hrdata;
        end
    end
    property p_pin_idle; !timer_output_pin_oe && !timer_output_pin; endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("output pin driven");
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus stalled or error");
    property p_trig_zero; rd && ap_a_r == gwt_pkg::OFS_TRIGGER |-> hrdata == 32'h0; endproperty
    a_trig_zero: assert property (p_trig_zero) else $error("trigger bits stuck");
    property p_cmp_back; rd && ap_a_r == gwt_pkg::OFS_COMPARE |-> hrdata == cmp_r; endproperty
    a_cmp_back: assert property (p_cmp_back) else $error("compare readback");
    property p_status_en;
        rd && ap_a_r == gwt_pkg::OFS_STATUS |-> hrdata[gwt_pkg::STS_ENABLED_BIT] == en_r;
    endproperty
    a_status_en: assert property (p_status_en) else $error("enabled flag");
    property p_frozen; rd && ap_a_r == gwt_pkg::OFS_COUNTER && lv_r |-> hrdata == lc_r; endproperty
    a_frozen: assert property (p_frozen) else $error("counter moved while stopped");
    property p_irq_short; $rose(channel_interrupt) |-> ##[1:8] !channel_interrupt; endproperty
    a_irq_short: assert property (p_irq_short) else $error("interrupt too long");
    property p_irq_run; $rose(channel_interrupt) |-> en_r; endproperty
    a_irq_run: assert property (p_irq_run) else $error("interrupt while stopped");
    property p_no_irq_start;
        wr && ap_a_r == gwt_pkg::OFS_TRIGGER && hwdata[0] |=> !channel_interrupt [*3];
    endproperty
    a_no_irq_start: assert property (p_no_irq_start) else $error("start interrupt");
    c_irq: cover property ($rose(channel_interrupt));
    c_frozen: cover property (rd && ap_a_r == gwt_pkg::OFS_COUNTER && lv_r);
    c_stop: cover property (wr && ap_a_r == gwt_pkg::OFS_TRIGGER && hwdata[1]);
endmodule
bind gwt_timer gwt_timer_props gwt_timer_props_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
    .timer_output_pin_oe(timer_output_pin_oe), .channel_interrupt(channel_interrupt)
);

// *** tb/gwt_timer_tb.sv ***
`timescale 1ns/10ps
module gwt_timer_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] lo;
        logic [31:0] hi;
    } gwt_note_t;
    localparam logic [31:0] MODE_CFG = 32'h0000_0218;
    localparam logic [31:0] MODE_PER = 32'h0000_021A;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = {1'b0, gwt_pkg::HSIZE_WORD};
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready, hreadyout, hresp, out_pin, out_oe, irq, pin;
    logic [31:0] hrdata, top;
    logic [31:0] lfsr = 32'h0000_C9FD;
    logic [31:0] pres = {gwt_pkg::DIV3_RST, gwt_pkg::DIV2_RST, gwt_pkg::DIV1_RST, gwt_pkg::DIV0_RST};
    logic level = 1'b0;
    logic irq_q = 1'b0;
    logic rd_dp = 1'b0;
    logic [3:0] lag = 4'h3;
    gwt_note_t q[$];
    gwt_note_t nt;
    int n_errors = 0;
    int n_tests = 0;
    int n_irq = 0;
    int n_irq_hi = 0;
    int cycles = 0;
    int w;
    assign hready = hreadyout;
    always #(gwt_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;
    gwt_timer gwt_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_input_pin(pin),
        .timer_output_pin(out_pin), .timer_output_pin_oe(out_oe), .channel_interrupt(irq));
    gwt_pin_model gwt_pin_model_i (.level(level), .lag(lag), .pin(pin));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_of_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] dat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= we;
        htrans <= gwt_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        rd_dp <= !we;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        xfer(1'b1, a, dat);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        q.push_back('{a, lo, hi});
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic chk(input string nm, input int exp, input int seen);
        n_tests++;
        if (seen != exp) begin
            n_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask
    // Drive one pin pulse of width cycles with a random lag, then wait 40 cycles
    task automatic pulse(input logic act, input int width);
        lfsr = next_rand(lfsr);
        lag <= lfsr[3:0];
        level <= act;
        repeat (width) @(posedge hclk);
        level <= !act;
        repeat (40) @(posedge hclk);
    endtask
    always @(posedge hclk) begin
        cycles++;
        irq_q <= irq;
        if (irq === 1'b1) n_irq_hi++;
        if (irq === 1'b1 && irq_q !== 1'b1) n_irq++;
        if (rd_dp === 1'b1 && hready === 1'b1) begin
            nt = q.pop_front();
            n_tests++;
            if (((hrdata >= nt.lo) && (hrdata <= nt.hi)) !== 1'b1) begin
                n_errors++;
                $display("wrong value reg %h expected %h to %h seen %h", nt.a, nt.lo, nt.hi, hrdata);
            end
        end
        if (cycles == 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, unmapped 1C reads zero
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), (i == 6) ? pres : 32'h0, (i == 6) ? pres : 32'h0);
        end
        wr(gwt_pkg::OFS_MODE_CONFIG, MODE_CFG);
        wr(gwt_pkg::OFS_EDGE_CONFIG, {30'h0, gwt_pkg::EDGE_HIGH_WIDTH});
        wr(gwt_pkg::OFS_COMPARE, gwt_pkg::ALL_ONES);
        rd(gwt_pkg::OFS_MODE_CONFIG, MODE_CFG, MODE_CFG);
        pulse(1'b1, 20);
        rd(gwt_pkg::OFS_COUNTER, 32'h0, 32'h0);
        wr(gwt_pkg::OFS_TRIGGER, 32'h1);
        rd(gwt_pkg::OFS_STATUS, 32'h1, 32'h1);
        rd(gwt_pkg::OFS_TRIGGER, 32'h0, 32'h0);
        w = 20 + lfsr[4:0];
        pulse(1'b1, w);
        top = gwt_pkg::ALL_ONES - 32'(w);
        rd(gwt_pkg::OFS_COUNTER, top - 3, top + 3);
        repeat (20) @(posedge hclk);
        rd(gwt_pkg::OFS_COUNTER, top - 3, top + 3);
        pulse(1'b1, w);
        top = top - 32'(w);
        rd(gwt_pkg::OFS_COUNTER, top - 4, top + 4);
        wr(gwt_pkg::OFS_TRIGGER, 32'h1);
        pulse(1'b1, w);
        top = top - 32'(w);
        rd(gwt_pkg::OFS_COUNTER, top - 5, top + 5);
        chk("irq count", 0, n_irq);
        wr(gwt_pkg::OFS_TRIGGER, 32'h3);
        rd(gwt_pkg::OFS_STATUS, 32'h0, 32'h0);
        pulse(1'b1, w);
        rd(gwt_pkg::OFS_COUNTER, top - 5, top + 5);
        // Low width run with a short reload value to reach zero
        level <= 1'b1;
        wr(gwt_pkg::OFS_EDGE_CONFIG, {30'h0, gwt_pkg::EDGE_LOW_WIDTH});
        wr(gwt_pkg::OFS_COMPARE, 32'h0000_0010);
        wr(gwt_pkg::OFS_TRIGGER, 32'h1);
        pulse(1'b0, 25);
        rd(gwt_pkg::OFS_COUNTER, 32'h4, 32'hC);
        chk("irq count", 1, n_irq);
        chk("irq cycles", 1, n_irq_hi);
        for (int k = 1; k < 4; k++) begin
            wr(gwt_pkg::OFS_TRIGGER, 32'h2);
            level <= 1'b0;
            wr(gwt_pkg::OFS_EDGE_CONFIG, {30'h0, gwt_pkg::EDGE_HIGH_WIDTH});
            wr(gwt_pkg::OFS_COMPARE, gwt_pkg::ALL_ONES);
            wr(gwt_pkg::OFS_MODE_CONFIG, MODE_CFG | (32'(k) << 14));
            wr(gwt_pkg::OFS_TRIGGER, 32'h1);
            pulse(1'b1, 64);
            top = gwt_pkg::ALL_ONES - (32'h40 >> k);
            rd(gwt_pkg::OFS_COUNTER, top - 3, top + 3);
        end
        // Period count: each restart clears the count; start interrupt on second run
        for (int k = 0; k < 2; k++) begin
            wr(gwt_pkg::OFS_TRIGGER, 32'h2);
            wr(gwt_pkg::OFS_MODE_CONFIG, MODE_PER | 32'(k));
            wr(gwt_pkg::OFS_TRIGGER, 32'h1);
            pulse(1'b1, 30);
            rd(gwt_pkg::OFS_COUNTER, 32'h1B, 32'h21);
        end
        chk("irq count", 2, n_irq);
        end_of_test();
    end
endmodule
